// File: pkg/dci_consts.vh
// Register map, field positions, reset values for deinterlacer control
`ifndef DCI_CONSTS_VH
`define DCI_CONSTS_VH

// Register byte offsets
`define DCI_OFS_GLOBAL     8'h00
`define DCI_OFS_STATUS     8'h04
`define DCI_OFS_EVT_EN     8'h08
`define DCI_OFS_MODE       8'h0C
`define DCI_OFS_LO_THR     8'h10
`define DCI_OFS_HI_THR     8'h14
`define DCI_OFS_XFADE      8'h18
`define DCI_OFS_SIZE       8'h1C
`define DCI_OFS_BLACK      8'h20
`define DCI_OFS_FLD_WORDS  8'h24
`define DCI_OFS_BASE0      8'h28
`define DCI_OFS_BASE1      8'h2C
`define DCI_OFS_BASE2      8'h30
`define DCI_OFS_STATE      8'h34

// Global register bits
`define DCI_G_ENABLE       0
`define DCI_G_UPD_REQ      1
`define DCI_G_CANCEL       2
`define DCI_G_BYPASS       3

// Mode register fields
`define DCI_M_PACK_LO      0
`define DCI_M_PACK_HI      1
`define DCI_M_KERN_LO      2
`define DCI_M_KERN_HI      3
`define DCI_M_ORDER_LO     4
`define DCI_M_ORDER_HI     5
`define DCI_M_COLOR        6
`define DCI_M_SCAN_LO      8
`define DCI_M_SCAN_HI      9
`define DCI_M_PULLDOWN     10
`define DCI_MODE_W         11

// Chroma packing, field order, scan structure codes
`define DCI_PACK_422       2'h0
`define DCI_PACK_420       2'h1
`define DCI_PACK_444       2'h2
`define DCI_ORDER_HD       2'h0
`define DCI_ORDER_PAL      2'h1
`define DCI_ORDER_NTSC     2'h2
`define DCI_SCAN_INTL      2'h0
`define DCI_SCAN_SEGF      2'h1
`define DCI_SCAN_PROG      2'h2

// Event flag positions
`define DCI_EV_UPDATED     0
`define DCI_EV_SYNCED      1
`define DCI_EV_LOST        2
`define DCI_EV_OVERRUN     3
`define DCI_EV_PD_ON       4
`define DCI_EV_PD_OFF      5
`define DCI_NUM_EV         11

// Field widths
`define DCI_THR_W          10
`define DCI_XF_W           21
`define DCI_DIM_W          12
`define DCI_BLK_W          12
`define DCI_FW_W           24

// Reset values
`define DCI_RST_GLOBAL     4'h1
`define DCI_RST_MODE       11'h000
`define DCI_RST_LO_THR     10'h00A
`define DCI_RST_HI_THR     10'h046
`define DCI_RST_XFADE      21'h004444
`define DCI_RST_XSIZE      12'h2D0
`define DCI_RST_YSIZE      12'h0F0
`define DCI_RST_BLACK      12'h000
`define DCI_RST_FLD_WORDS  24'h000000
`define DCI_RST_BASE       32'h00000000

`endif

// File: hdl/dci_ctrl.v
// Deinterlacer control front end: APB register bank and frame-locked update
//
// How it works
// - Global register lives in the bus domain
// - Config registers locked while update pending
// - Frame boundary copies all staged settings together
// - Cancel through global register acts at once
// - Eleven events, each flag enabled and cleared
// - Event when requested update takes effect
// - Event when raster matches programmed sizes
// - Event when raster lost or mismatched
// - Event on input FIFO overrun
// - Events on pull-down cadence start and end
// - One bus access at a time
// - Write before read when both arrive
// - Parallel request loads at frame, then done
// - Chroma packing picks 4:2:2, 4:2:0, 4:4:4
// - Runtime motion thresholds and cross-fade factor
// - Field order and colour space, black value
// - Three field buffer bases, words per field
// - Scan structure select and pull-down enable
// - Rolling three field buffers, one written
// - One memory port, 32 to 256 bits
`include "dci_consts.vh"

module dci_ctrl #(
   parameter MEM_DW = 32
) (
   input  wire                    mclk,
   input  wire                    rst_b,
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [7:0]              paddr,
   input  wire [31:0]             pwdata,
   output wire                    pready,
   output reg  [31:0]             prdata,
   output reg                     pslverr,
   input  wire [`DCI_NUM_EV-1:1]  vid_event_in,
   input  wire                    frame_tick_in,
   input  wire                    par_upd_req,
   output reg                     par_upd_done,
   output reg  [`DCI_NUM_EV-1:0]  event_status,
   output reg                     core_enable,
   output reg                     core_bypass,
   output reg  [`DCI_MODE_W-1:0]  act_mode,
   output reg  [`DCI_THR_W-1:0]   act_lo_thr,
   output reg  [`DCI_THR_W-1:0]   act_hi_thr,
   output reg  [`DCI_XF_W-1:0]    act_xfade,
   output reg  [`DCI_DIM_W-1:0]   act_xsize,
   output reg  [`DCI_DIM_W-1:0]   act_ysize,
   output reg  [`DCI_BLK_W-1:0]   act_black,
   output reg  [`DCI_FW_W-1:0]    act_field_beats,
   output reg  [31:0]             wr_field_base,
   output reg  [31:0]             rd1_field_base,
   output reg  [31:0]             rd2_field_base
);

   // Memory port width steps the beat count down from 32-bit words
   localparam [1:0] BEAT_SH = (MEM_DW == 256) ? 2'd3 :
                              (MEM_DW == 128) ? 2'd2 :
                              (MEM_DW == 64)  ? 2'd1 : 2'd0;
   localparam SW = `DCI_NUM_EV + 1;

   // Staged registers (bus side)
   reg  [3:0]              global_r;
   reg  [`DCI_NUM_EV-1:0]  flags_r;
   reg  [`DCI_NUM_EV-1:0]  evt_en_r;
   reg  [`DCI_MODE_W-1:0]  mode_r;
   reg  [`DCI_THR_W-1:0]   lo_thr_r;
   reg  [`DCI_THR_W-1:0]   hi_thr_r;
   reg  [`DCI_XF_W-1:0]    xfade_r;
   reg  [`DCI_DIM_W-1:0]   xsize_r;
   reg  [`DCI_DIM_W-1:0]   ysize_r;
   reg  [`DCI_BLK_W-1:0]   black_r;
   reg  [`DCI_FW_W-1:0]    fld_words_r;
   reg  [31:0]             base0_r;
   reg  [31:0]             base1_r;
   reg  [31:0]             base2_r;

   // Active copies of the bases and rotation state
   reg  [31:0]             act_base0_r;
   reg  [31:0]             act_base1_r;
   reg  [31:0]             act_base2_r;
   reg  [1:0]              buf_idx_r;
   reg                     pending_r;
   reg                     par_src_r;

   // Synchronisers: events, frame tick, parallel request
   reg  [SW-1:0]           sync1_r;
   reg  [SW-1:0]           sync2_r;
   reg  [SW-1:0]           sync3_r;

   wire                    wr_acc;
   wire                    rd_setup;
   wire                    cfg_wr;
   wire                    upd_wr;
   wire                    cancel_wr;
   wire                    par_rise;
   wire                    frame_edge;
   wire                    do_load;
   wire [`DCI_NUM_EV-1:0]  ev_set;
   wire [`DCI_NUM_EV-1:0]  ev_clr;

   // Address decode shared by write and error paths
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a[1:0] == 2'b00) && (a <= `DCI_OFS_STATE);
      end
   endfunction

   // Staged configuration, excluding global, status, enable and state
   function is_cfg;
      input [7:0] a;
      begin
         is_cfg = is_mapped(a) && (a >= `DCI_OFS_MODE) &&
                  (a != `DCI_OFS_STATE);
      end
   endfunction

   // Pick one of three bases by rolling index
   function [31:0] pick_base;
      input [1:0]  idx;
      input [31:0] b0;
      input [31:0] b1;
      input [31:0] b2;
      begin
         case (idx)
            2'd0:    pick_base = b0;
            2'd1:    pick_base = b1;
            default: pick_base = b2;
         endcase
      end
   endfunction

   // Index one step back around the ring of three
   function [1:0] prev_idx;
      input [1:0] idx;
      begin
         prev_idx = (idx == 2'd0) ? 2'd2 : idx - 2'd1;
      end
   endfunction

   // APB: zero-wait slave, one transfer in flight by protocol
   assign pready   = psel & penable;
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign cfg_wr   = wr_acc & is_cfg(paddr) & ~pending_r;
   assign upd_wr   = wr_acc & (paddr == `DCI_OFS_GLOBAL) &
                     pwdata[`DCI_G_UPD_REQ];
   assign cancel_wr = wr_acc & (paddr == `DCI_OFS_GLOBAL) &
                      pwdata[`DCI_G_CANCEL];

   // Synchronised edges; second and third stages only feed logic
   assign frame_edge = sync2_r[0] & ~sync3_r[0];
   assign par_rise   = sync2_r[1] & ~sync3_r[1];
   // Cancel blocks a load landing in the same cycle
   assign do_load    = frame_edge & pending_r & ~cancel_wr;

   // Event sources: internal update plus edges of video-side levels
   assign ev_set = {sync2_r[SW-1:2] & ~sync3_r[SW-1:2],
                    do_load};
   assign ev_clr = (wr_acc && paddr == `DCI_OFS_STATUS) ?
                   pwdata[`DCI_NUM_EV-1:0] : {`DCI_NUM_EV{1'b0}};

   // Two-flop synchroniser plus edge history
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= {SW{1'b0}};
         sync2_r <= {SW{1'b0}};
         sync3_r <= {SW{1'b0}};
      end else begin
         sync1_r <= {vid_event_in, par_upd_req, frame_tick_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Global register always writable, even while locked
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         global_r <= `DCI_RST_GLOBAL;
      end else if (wr_acc && paddr == `DCI_OFS_GLOBAL) begin
         global_r[`DCI_G_ENABLE] <= pwdata[`DCI_G_ENABLE];
         global_r[`DCI_G_BYPASS] <= pwdata[`DCI_G_BYPASS];
         global_r[2:1]           <= 2'b00;
      end
   end

   // Pending update: cancel is immediate and beats a new request
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pending_r <= 1'b0;
         par_src_r <= 1'b0;
      end else if (cancel_wr) begin
         pending_r <= 1'b0;
         par_src_r <= 1'b0;
      end else if (upd_wr || par_rise) begin
         pending_r <= 1'b1;
         par_src_r <= par_src_r | par_rise;
      end else if (do_load) begin
         pending_r <= 1'b0;
         par_src_r <= 1'b0;
      end
   end

   // Done holds until the parallel request falls
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         par_upd_done <= 1'b0;
      end else if (do_load && par_src_r) begin
         par_upd_done <= 1'b1;
      end else if (!sync2_r[1]) begin
         par_upd_done <= 1'b0;
      end
   end

   // Sticky flags, set wins over a write-one clear
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         flags_r      <= {`DCI_NUM_EV{1'b0}};
         evt_en_r     <= {`DCI_NUM_EV{1'b0}};
         event_status <= {`DCI_NUM_EV{1'b0}};
      end else begin
         flags_r <= (flags_r & ~ev_clr) | ev_set;
         if (wr_acc && paddr == `DCI_OFS_EVT_EN)
            evt_en_r <= pwdata[`DCI_NUM_EV-1:0];
         event_status <= flags_r & evt_en_r;
      end
   end

   // Staged configuration writes, refused while an update waits
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mode_r      <= `DCI_RST_MODE;
         lo_thr_r    <= `DCI_RST_LO_THR;
         hi_thr_r    <= `DCI_RST_HI_THR;
         xfade_r     <= `DCI_RST_XFADE;
         xsize_r     <= `DCI_RST_XSIZE;
         ysize_r     <= `DCI_RST_YSIZE;
         black_r     <= `DCI_RST_BLACK;
         fld_words_r <= `DCI_RST_FLD_WORDS;
         base0_r     <= `DCI_RST_BASE;
         base1_r     <= `DCI_RST_BASE;
         base2_r     <= `DCI_RST_BASE;
      end else if (cfg_wr) begin
         case (paddr)
            `DCI_OFS_MODE: mode_r <= pwdata[`DCI_MODE_W-1:0];
            `DCI_OFS_LO_THR:    lo_thr_r <= pwdata[`DCI_THR_W-1:0];
            `DCI_OFS_HI_THR:    hi_thr_r <= pwdata[`DCI_THR_W-1:0];
            `DCI_OFS_XFADE:     xfade_r <= pwdata[`DCI_XF_W-1:0];
            `DCI_OFS_SIZE: begin
               xsize_r <= pwdata[`DCI_DIM_W-1:0];
               ysize_r <= pwdata[16+`DCI_DIM_W-1:16];
            end
            `DCI_OFS_BLACK:     black_r <= pwdata[`DCI_BLK_W-1:0];
            `DCI_OFS_FLD_WORDS: fld_words_r <= pwdata[`DCI_FW_W-1:0];
            `DCI_OFS_BASE0:     base0_r <= pwdata;
            `DCI_OFS_BASE1:     base1_r <= pwdata;
            `DCI_OFS_BASE2:     base2_r <= pwdata;
            default: begin
            end
         endcase
      end
   end

   // All settings move to the active side in one cycle
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         act_mode        <= `DCI_RST_MODE;
         act_lo_thr      <= `DCI_RST_LO_THR;
         act_hi_thr      <= `DCI_RST_HI_THR;
         act_xfade       <= `DCI_RST_XFADE;
         act_xsize       <= `DCI_RST_XSIZE;
         act_ysize       <= `DCI_RST_YSIZE;
         act_black       <= `DCI_RST_BLACK;
         act_field_beats <= `DCI_RST_FLD_WORDS;
         act_base0_r     <= `DCI_RST_BASE;
         act_base1_r     <= `DCI_RST_BASE;
         act_base2_r     <= `DCI_RST_BASE;
      end else if (do_load) begin
         act_mode        <= mode_r;
         act_lo_thr      <= lo_thr_r;
         act_hi_thr      <= hi_thr_r;
         act_xfade       <= xfade_r;
         act_xsize       <= xsize_r;
         act_ysize       <= ysize_r;
         act_black       <= black_r;
         act_field_beats <= fld_words_r >> BEAT_SH;
         act_base0_r     <= base0_r;
         act_base1_r     <= base1_r;
         act_base2_r     <= base2_r;
      end
   end

   // Global controls go out straight from the bus-side register
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         core_enable <= 1'b0;
         core_bypass <= 1'b0;
      end else begin
         core_enable <= global_r[`DCI_G_ENABLE];
         core_bypass <= global_r[`DCI_G_BYPASS];
      end
   end

   // Ring of three buffers: write n, read n-1 and n-2
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         buf_idx_r      <= 2'd0;
         wr_field_base  <= `DCI_RST_BASE;
         rd1_field_base <= `DCI_RST_BASE;
         rd2_field_base <= `DCI_RST_BASE;
      end else begin
         if (frame_edge && global_r[`DCI_G_ENABLE])
            buf_idx_r <= (buf_idx_r == 2'd2) ? 2'd0 :
                         buf_idx_r + 2'd1;
         wr_field_base  <= pick_base(buf_idx_r, act_base0_r,
                                     act_base1_r, act_base2_r);
         rd1_field_base <= pick_base(prev_idx(buf_idx_r), act_base0_r,
                                     act_base1_r, act_base2_r);
         rd2_field_base <= pick_base(prev_idx(prev_idx(buf_idx_r)),
                                     act_base0_r, act_base1_r,
                                     act_base2_r);
      end
   end

   // Read data and error captured in setup, stable through access
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= ~is_mapped(paddr);
         prdata  <= 32'h00000000;
         if (rd_setup) begin
            case (paddr)
               `DCI_OFS_GLOBAL:
                  prdata <= {28'h0000000, global_r[3],
                             1'b0, pending_r, global_r[0]};
               `DCI_OFS_STATUS:    prdata[`DCI_NUM_EV-1:0] <= flags_r;
               `DCI_OFS_EVT_EN:    prdata[`DCI_NUM_EV-1:0] <= evt_en_r;
               `DCI_OFS_MODE:      prdata[`DCI_MODE_W-1:0] <= mode_r;
               `DCI_OFS_LO_THR:    prdata[`DCI_THR_W-1:0] <= lo_thr_r;
               `DCI_OFS_HI_THR:    prdata[`DCI_THR_W-1:0] <= hi_thr_r;
               `DCI_OFS_XFADE:     prdata[`DCI_XF_W-1:0] <= xfade_r;
               `DCI_OFS_SIZE: begin
                  prdata[`DCI_DIM_W-1:0]       <= xsize_r;
                  prdata[16+`DCI_DIM_W-1:16]   <= ysize_r;
               end
               `DCI_OFS_BLACK:     prdata[`DCI_BLK_W-1:0] <= black_r;
               `DCI_OFS_FLD_WORDS: prdata[`DCI_FW_W-1:0] <= fld_words_r;
               `DCI_OFS_BASE0:     prdata <= base0_r;
               `DCI_OFS_BASE1:     prdata <= base1_r;
               `DCI_OFS_BASE2:     prdata <= base2_r;
               `DCI_OFS_STATE:
                  prdata <= {27'h0000000, par_upd_done, buf_idx_r,
                             par_src_r, pending_r};
               default:            prdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// File: bench/dci_ctrl_properties.sv
// Port-level checks for the deinterlacer control front end
`include "dci_consts.vh"
module dci_ctrl_properties (
   input logic                   mclk,
   input logic                   rst_b,
   input logic                   psel,
   input logic                   penable,
   input logic                   pwrite,
   input logic [7:0]             paddr,
   input logic [31:0]            pwdata,
   input logic                   pready,
   input logic                   pslverr,
   input logic                   frame_tick_in,
   input logic                   par_upd_req,
   input logic                   par_upd_done,
   input logic [`DCI_NUM_EV-1:0] event_status,
   input logic                   core_enable,
   input logic                   core_bypass,
   input logic [`DCI_MODE_W-1:0] act_mode,
   input logic [`DCI_DIM_W-1:0]  act_xsize,
   input logic [31:0]            wr_field_base
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  tick_age_r;
   logic [3:0]  tick_age_nxt;
   logic [31:0] pwd_r;
   logic        clr_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Cycles since the frame tick was last high, saturating
   assign tick_age_nxt = frame_tick_in ? 4'h0 :
                         (tick_age_r == 4'hF) ? 4'hF : tick_age_r + 4'h1;
   // Helpers kept one cycle so the checks can look back at the cause
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tick_age_r <= 4'hF;
         pwd_r      <= 32'h0;
         clr_r      <= 1'b0;
      end else begin
         tick_age_r <= tick_age_nxt;
         pwd_r      <= pwdata;
         clr_r      <= psel & penable & pwrite &
                       (paddr == `DCI_OFS_STATUS || paddr == `DCI_OFS_EVT_EN);
      end
   end
   sequence s_glob_wr;
      psel && penable && pwrite && paddr == `DCI_OFS_GLOBAL;
   endsequence
   sequence s_cancel_wr;
      s_glob_wr ##0 pwdata[`DCI_G_CANCEL];
   endsequence
   property p_ready;
      pready == (psel && penable);
   endproperty
   a_ready: assert property (p_ready) else $error("pready off access");
   property p_slverr;
      psel && !penable && (paddr > 8'h34 || paddr[1:0] != 2'h0) |=> pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("no slave error");
   property p_glob;
      s_glob_wr |-> ##2 {core_bypass, core_enable} ==
                        {$past(pwd_r[3]), $past(pwd_r[0])};
   endproperty
   a_glob: assert property (p_glob) else $error("global bits lost");
   property p_cancel;
      s_cancel_wr |=> $stable(act_mode) [*8];
   endproperty
   a_cancel: assert property (p_cancel) else $error("load after cancel");
   property p_load;
      !$stable(act_mode) || !$stable(act_xsize) |-> tick_age_r <= 4'h6;
   endproperty
   a_load: assert property (p_load) else $error("load off frame");
   property p_ring;
      !$stable(wr_field_base) |-> tick_age_r <= 4'h6;
   endproperty
   a_ring: assert property (p_ring) else $error("ring moved off frame");
   property p_done_rise;
      $rose(par_upd_done) |-> par_upd_req && tick_age_r <= 4'h8;
   endproperty
   a_done_rise: assert property (p_done_rise) else $error("early done");
   property p_done_fall;
      $fell(par_upd_done) |-> !$past(par_upd_req, 2);
   endproperty
   a_done_fall: assert property (p_done_fall) else $error("done dropped");
   property p_evt_clr;
      |($past(event_status) & ~event_status) |-> $past(clr_r);
   endproperty
   a_evt_clr: assert property (p_evt_clr) else $error("flag lost");
endmodule
bind dci_ctrl dci_ctrl_properties i_props (.mclk, .rst_b, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .frame_tick_in,
   .par_upd_req, .par_upd_done, .event_status, .core_enable, .core_bypass,
   .act_mode, .act_xsize, .wr_field_base);

// File: bench/dci_host_model.sv
// APB master standing in for the host processor
module dci_host_model (
   input  logic        mclk,
   output logic        psel,
   output logic        penable,
   output logic        pwrite,
   output logic [7:0]  paddr,
   output logic [31:0] pwdata,
   input  logic        pready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer at a time; the leading edge keeps drives apart
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d; // Released data must not look valid
   endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the deinterlacer control front end
`include "dci_consts.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   mclk, rst_b, tick, preq;
   logic [`DCI_NUM_EV-1:1] vid_ev;
   wire                    psel, penable, pwrite, pready, pslverr, pdone;
   wire [7:0]              paddr;
   wire [31:0]             pwdata, prdata, b_wr, b_r1, b_r2;
   wire [`DCI_NUM_EV-1:0]  ev_st;
   wire [`DCI_MODE_W-1:0]  a_mode;
   wire                    c_en, c_by;
   wire [`DCI_THR_W-1:0]   a_lo, a_hi;
   wire [`DCI_XF_W-1:0]    a_xf;
   wire [`DCI_DIM_W-1:0]   a_xs, a_ys;
   wire [`DCI_BLK_W-1:0]   a_bk;
   wire [`DCI_FW_W-1:0]    a_fw;
   logic [32:0]            exp_q[$];
   int                     miscompares, n_tests, n_tick;
   integer                 seed;
   logic [31:0]            base[3];
   logic [31:0]            m, xf, sz, r;
   logic [23:0]            fw;
   logic [9:0]             lo, hi;
   dci_host_model i_host (.mclk(mclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
   dci_ctrl #(.MEM_DW(64)) i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .vid_event_in(vid_ev), .frame_tick_in(tick), .par_upd_req(preq),
      .par_upd_done(pdone), .event_status(ev_st), .core_enable(c_en),
      .core_bypass(c_by), .act_mode(a_mode), .act_lo_thr(a_lo),
      .act_hi_thr(a_hi), .act_xfade(a_xf), .act_xsize(a_xs),
      .act_ysize(a_ys), .act_black(a_bk),
      .act_field_beats(a_fw), .wr_field_base(b_wr), .rd1_field_base(b_r1),
      .rd2_field_base(b_r2));
   // 250 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      i_host.xfer(1'b0, a, 32'h0);
   endtask
   // Frame boundary pulse, long enough to pass the synchronisers
   task automatic frame();
      @(posedge mclk);
      tick <= 1'b1;
      repeat (8) @(posedge mclk);
      tick <= 1'b0;
      repeat (8) @(posedge mclk);
      n_tick++;
   endtask
   task automatic ring();
      int k;
      k = n_tick % 3;
      chk(b_wr, base[k]);
      chk(b_r1, base[(k + 2) % 3]);
      chk(b_r2, base[(k + 1) % 3]);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Read monitor: oldest note against each completed read
   always @(posedge mclk) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1) begin
         if (exp_q.size() == 0) chk(33'h1FFFFFFFF, 33'h0);
         else chk({pslverr, prdata}, exp_q.pop_front());
      end
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      test_done();
   end
   initial begin
      seed = 32'h2b37e17a;
      rst_b = 1'b0;
      tick = 1'b0;
      preq = 1'b0;
      vid_ev = '0;
      base = '{default: 32'h0};
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      // Reset values, read-only state, refused addresses
      wr(`DCI_OFS_STATE, 32'hFFFFFFFF);
      rd(`DCI_OFS_STATE, 33'h0);
      rd(`DCI_OFS_GLOBAL, {29'h0, `DCI_RST_GLOBAL});
      rd(`DCI_OFS_LO_THR, {23'h0, `DCI_RST_LO_THR});
      rd(`DCI_OFS_XFADE, {12'h0, `DCI_RST_XFADE});
      rd(`DCI_OFS_SIZE, {5'h0, `DCI_RST_YSIZE, 4'h0, `DCI_RST_XSIZE});
      rd(8'h38, {1'b1, 32'h0});
      rd(8'h02, {1'b1, 32'h0});
      wr(`DCI_OFS_EVT_EN, 32'h7FF);
      // Staged update per code, lock while pending, frame load
      for (int i = 0; i < 3; i++) begin
         lo = 10'($random(seed)) & 10'h1FF;
         hi = lo + 10'd1 + (10'($random(seed)) & 10'hFF);
         r = $random(seed);
         m = {21'h0, i[0], i[1:0], 1'b0, i[0], i[1:0], r[1:0], i[1:0]};
         xf = 32'h100000 / {22'h0, hi - lo};
         sz = {4'h0, r[27:16], 4'h0, r[11:2], 2'b00};
         fw = 24'($random(seed));
         wr(`DCI_OFS_MODE, m);
         wr(`DCI_OFS_LO_THR, {22'h0, lo});
         wr(`DCI_OFS_HI_THR, {22'h0, hi});
         wr(`DCI_OFS_XFADE, xf);
         wr(`DCI_OFS_SIZE, sz);
         wr(`DCI_OFS_FLD_WORDS, {8'h0, fw});
         wr(`DCI_OFS_BLACK, {20'h0, r[31:20]});
         for (int j = 0; j < 3; j++) begin
            base[j] = $random(seed);
            wr(`DCI_OFS_BASE0 + 8'(4 * j), base[j]);
         end
         wr(`DCI_OFS_GLOBAL, 32'h3);
         rd(`DCI_OFS_STATE, {28'h0, 1'b0, 2'(n_tick % 3), 2'b01});
         wr(`DCI_OFS_MODE, ~m);
         rd(`DCI_OFS_MODE, {1'b0, m});
         frame();
         chk(a_mode, m[10:0]);
         chk(a_lo, lo);
         chk(a_hi, hi);
         chk(a_xf, xf[20:0]);
         chk(a_xs, sz[11:0]);
         chk(a_ys, sz[27:16]);
         chk(a_bk, r[31:20]);
         chk(a_fw, fw >> 1);
         ring();
         chk(ev_st, 11'h1);
         wr(`DCI_OFS_STATUS, 32'h1);
      end
      // Cancel drops the pending load; enable and bypass still take effect
      wr(`DCI_OFS_MODE, 32'h0);
      wr(`DCI_OFS_GLOBAL, 32'h3);
      wr(`DCI_OFS_GLOBAL, 32'hD);
      frame();
      chk(a_mode, m[10:0]);
      rd(`DCI_OFS_GLOBAL, 33'h9);
      chk({c_by, c_en}, 2'b11);
      rd(`DCI_OFS_STATUS, 33'h0);
      // Each video-side event sets its own flag and clears alone
      for (int b = 1; b < `DCI_NUM_EV; b++) begin
         vid_ev <= 10'h1 << (b - 1);
         repeat (6) @(posedge mclk);
         vid_ev <= '0;
         rd(`DCI_OFS_STATUS, {1'b0, 32'h1 << b});
         chk(ev_st, 11'h1 << b);
         wr(`DCI_OFS_STATUS, 32'h1 << b);
         rd(`DCI_OFS_STATUS, 33'h0);
      end
      // Disabled event still flags but stays off the output
      wr(`DCI_OFS_EVT_EN, 32'h0);
      vid_ev <= 10'h4;
      repeat (6) @(posedge mclk);
      vid_ev <= '0;
      chk(ev_st, 11'h0);
      rd(`DCI_OFS_STATUS, {1'b0, 32'h8});
      // Parallel request: load at frame, then done, then release
      wr(`DCI_OFS_MODE, 32'h555);
      @(posedge mclk);
      preq <= 1'b1;
      repeat (8) @(posedge mclk);
      chk(pdone, 1'b0);
      frame();
      chk(pdone, 1'b1);
      chk(a_mode, 11'h555);
      ring();
      preq <= 1'b0;
      for (int w = 0; w < 20 && pdone !== 1'b0; w++) @(posedge mclk);
      chk(pdone, 1'b0);
      test_done();
   end
endmodule
